// >>> hdl/gilr_bank_check.sv
// Register bank limit check for banked interrupt entry.
`timescale 1ns/100ps
`default_nettype none
module gilr_bank_check (
    input wire logic uses_bank,
    input wire logic [5:0] current_bank_index,
    input wire logic [5:0] bank_number_upper_limit,
    output logic bank_fault
);

    // A bank is unusable above the limit, and index 63 never is usable.
    always_comb begin
        bank_fault = uses_bank &&
            ((current_bank_index > bank_number_upper_limit) ||
             (current_bank_index == gilr_pkg::GILR_BANK_INVALID)); // [RULE3]
    end

endmodule : gilr_bank_check
`default_nettype wire

// >>> hdl/gilr_prio_gate.sv
// Priority mask gate for external maskable interrupts.
`timescale 1ns/100ps
`default_nettype none
module gilr_prio_gate (
    input wire logic [5:0] priority_level,
    input wire logic [5:0] priority_mask_level,
    input wire logic interrupt_disable_flag,
    output logic admit
);

    // Only priorities strictly below the mask level pass, so a mask of 0
    // blocks all and priority 63 can never pass.
    always_comb begin
        admit = !interrupt_disable_flag &&
            (priority_mask_level != 6'h00) && // [RULE7]
            (priority_level < priority_mask_level); // [RULE6]
    end

endmodule : gilr_prio_gate
`default_nettype wire

// >>> hdl/gilr_regs.sv
// Guest interrupt configuration, priority mask and supervisor lock registers.
//
// Overview of operation
// RULE1: Table base gives address bits 31..9, low zero.
// RULE2: Bank limit field bits 21..16, writable, resets 0F.
// RULE3: Banked interrupt beyond limit or 63: hold, error.
// RULE4: Priority extension bit 1 reads constant one.
// RULE5: In-service update bit 0 reads constant zero.
// RULE6: Mask field resets 3F, blocks priorities at/above.
// RULE7: Mask zero inhibits all, like interrupt disable.
// RULE8: Lock set: supervisor protection writes leave registers. Direct GMPM writes pass here too.
// RULE9: Reserved fields read-only, read zero.
// RULE10: Configuration bits 31..22 read-only, undefined.
// RULE11: Direct guest protection ID writes pass despite lock.
// RULE12: Ignored writes raise no exception, keep values.
`timescale 1ns/100ps
`default_nettype none
module gilr_regs (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire gilr_pkg::gilr_sr_req_t sr_req,
    input wire logic [31:0] sr_wdata,
    output logic [31:0] sr_rdata,
    output logic sr_rd_valid,
    input wire gilr_pkg::gilr_irq_t irq_req,
    input wire logic interrupt_disable_flag,
    input wire logic [5:0] current_bank_index,
    output logic irq_accept,
    output logic irq_hold,
    output logic system_error_exception,
    input wire gilr_pkg::gilr_prot_req_t prot_req,
    output logic prot_wr_allow,
    output logic prot_wr_blocked,
    output logic [31:0] table_base_addr,
    output logic [5:0] bank_number_upper_limit,
    output logic [5:0] priority_mask_level,
    output logic supervisor_lock_flag
);

    // Stored fields; every other bit of the four registers is constant.
    logic [22:0] table_base_field_r;
    logic [5:0] limit_r;
    logic [5:0] mask_r;
    logic lock_r;

    // Write strobes per register.
    logic wr_table_base;
    logic wr_int_config;
    logic wr_prio_mask;
    logic wr_sv_lock;

    // Read path registers.
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic rd_valid_r;

    // Interrupt decision results.
    logic admit;
    logic bank_fault;
    logic accept_r;
    logic hold_r;
    logic system_error_exception_r;

    // Protection write gating.
    logic prot_locked;
    logic blocked_r;

    // Register images as seen by software.
    logic [31:0] img_table_base;
    logic [31:0] img_int_config;
    logic [31:0] img_prio_mask;
    logic [31:0] img_sv_lock;

    // Decode a write to one register; the four registers themselves are
    // not guarded by the lock, only the protection registers are.
    always_comb begin
        wr_table_base = sr_req.wr &&
            (sr_req.sel == gilr_pkg::GILR_SEL_TABLE_BASE);
        wr_int_config = sr_req.wr &&
            (sr_req.sel == gilr_pkg::GILR_SEL_INT_CONFIG);
        wr_prio_mask = sr_req.wr &&
            (sr_req.sel == gilr_pkg::GILR_SEL_PRIO_MASK);
        wr_sv_lock = sr_req.wr &&
            (sr_req.sel == gilr_pkg::GILR_SEL_SV_LOCK);
    end

    // Table base field; the low nine bits are never stored.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            table_base_field_r <= gilr_pkg::GILR_TBASE_RST;
        end else if (wr_table_base) begin
            table_base_field_r <= sr_wdata[gilr_pkg::GILR_TBASE_MSB:
                gilr_pkg::GILR_TBASE_LSB]; // [RULE1]
        end
    end

    // Bank limit field; the two low bits of this register are constants,
    // so writes to them simply have no target.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            limit_r <= gilr_pkg::GILR_LIMIT_RST; // [RULE2]
        end else if (wr_int_config) begin
            limit_r <= sr_wdata[gilr_pkg::GILR_LIMIT_MSB:
                gilr_pkg::GILR_LIMIT_LSB]; // [RULE2]
        end
    end

    // Priority mask level.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            mask_r <= gilr_pkg::GILR_MASK_RST; // [RULE6]
        end else if (wr_prio_mask) begin
            mask_r <= sr_wdata[gilr_pkg::GILR_MASK_MSB:
                gilr_pkg::GILR_MASK_LSB];
        end
    end

    // Supervisor lock flag.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            lock_r <= gilr_pkg::GILR_LOCK_RST; // [RULE8]
        end else if (wr_sv_lock) begin
            lock_r <= sr_wdata[gilr_pkg::GILR_LOCK_BIT];
        end
    end

    // Software images. Reserved bits are tied off here, so a write that
    // sets them is dropped silently and no fault is signalled.
    always_comb begin
        img_table_base = {table_base_field_r, 9'h000}; // [RULE9] [RULE12]
    end

    // Configuration image. The two low bits are wired constants, so a
    // guest can never switch priority extension off or bring back
    // in-service priority updates.
    always_comb begin
        img_int_config = 32'h00000000; // [RULE9]
        // The upper reserved bits are undefined; zero is a legal choice.
        img_int_config[31:22] = 10'h000; // [RULE10]
        img_int_config[gilr_pkg::GILR_LIMIT_MSB:
            gilr_pkg::GILR_LIMIT_LSB] = limit_r;
        img_int_config[gilr_pkg::GILR_EXT_BIT] =
            gilr_pkg::GILR_EXT_VALUE; // [RULE4]
        img_int_config[gilr_pkg::GILR_ISP_BIT] =
            gilr_pkg::GILR_ISP_VALUE; // [RULE5]
    end

    // Priority mask image; only the six level bits are stored.
    always_comb begin
        img_prio_mask = 32'h00000000; // [RULE9]
        img_prio_mask[gilr_pkg::GILR_MASK_MSB:
            gilr_pkg::GILR_MASK_LSB] = mask_r;
    end

    // Lock image; only the flag itself is stored.
    always_comb begin
        img_sv_lock = 32'h00000000; // [RULE9]
        img_sv_lock[gilr_pkg::GILR_LOCK_BIT] = lock_r;
    end

    // Read multiplexer; an unknown selector reads as zero.
    always_comb begin
        case (sr_req.sel)
            gilr_pkg::GILR_SEL_TABLE_BASE: begin
                rdata_nxt = img_table_base;
            end
            gilr_pkg::GILR_SEL_INT_CONFIG: begin
                rdata_nxt = img_int_config;
            end
            gilr_pkg::GILR_SEL_PRIO_MASK: begin
                rdata_nxt = img_prio_mask;
            end
            gilr_pkg::GILR_SEL_SV_LOCK: begin
                rdata_nxt = img_sv_lock;
            end
            default: begin
                rdata_nxt = 32'h00000000;
            end
        endcase
    end

    // Read data is registered, so a read in the same cycle as a write to
    // the same register returns the value from before that write.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rdata_r <= 32'h00000000;
        end else if (sr_req.rd) begin
            rdata_r <= rdata_nxt;
        end
    end

    // The valid strobe stands for exactly one cycle per read request.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rd_valid_r <= 1'b0;
        end else begin
            rd_valid_r <= sr_req.rd;
        end
    end

    // Priority mask comparison.
    gilr_prio_gate u_prio_gate (
        .priority_level(irq_req.priority_level),
        .priority_mask_level(mask_r),
        .interrupt_disable_flag(interrupt_disable_flag),
        .admit(admit)
    );

    // Register bank limit comparison.
    gilr_bank_check u_bank_check (
        .uses_bank(irq_req.uses_bank),
        .current_bank_index(current_bank_index),
        .bank_number_upper_limit(limit_r),
        .bank_fault(bank_fault)
    );

    // Interrupt decision, one cycle after the request is offered. Only an
    // interrupt that passes the mask can run into the bank check; a masked
    // one is simply not taken and raises nothing.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            accept_r <= 1'b0;
        end else begin
            accept_r <= irq_req.valid && admit && !bank_fault; // [RULE6]
        end
    end

    // A banked interrupt that fails the bank check is held rather than
    // taken; the request itself stays pending at its source.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            hold_r <= 1'b0;
        end else begin
            hold_r <= irq_req.valid && admit && bank_fault; // [RULE3]
        end
    end

    // The system error is raised in the same cycle as the hold, so the
    // handler finds the refused request still pending.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            system_error_exception_r <= 1'b0;
        end else begin
            system_error_exception_r <= irq_req.valid && admit && bank_fault; // [RULE3]
        end
    end

    // The lock bites only on supervisor writes, to every target but the two direct ones;
    // direct writes to the guest copies stay open so the hypervisor can
    // still prepare them while the guest is locked.
    always_comb begin
        case (prot_req.target)
            gilr_pkg::GILR_PT_GPID_DIRECT: begin
                prot_locked = 1'b0; // [RULE11]
            end
            gilr_pkg::GILR_PT_GMPM_DIRECT: begin
                prot_locked = 1'b0;
            end
            gilr_pkg::GILR_PT_GPID_ACTIVE: begin
                prot_locked = lock_r && prot_req.sv_mode; // [RULE8]
            end
            gilr_pkg::GILR_PT_GMPM_ACTIVE: begin
                prot_locked = lock_r && prot_req.sv_mode; // [RULE8]
            end
            gilr_pkg::GILR_PT_MPU_LOWER: begin
                prot_locked = lock_r && prot_req.sv_mode; // [RULE8]
            end
            gilr_pkg::GILR_PT_MPU_UPPER: begin
                prot_locked = lock_r && prot_req.sv_mode; // [RULE8]
            end
            gilr_pkg::GILR_PT_MPU_ATTR: begin
                prot_locked = lock_r && prot_req.sv_mode; // [RULE8]
            end
            gilr_pkg::GILR_PT_MPU_IDBANK: begin
                prot_locked = lock_r && prot_req.sv_mode; // [RULE8]
            end
            default: begin
                prot_locked = lock_r && prot_req.sv_mode; // [RULE8]
            end
        endcase
    end

    // Blocked writes are reported as a pulse for the register owner only;
    // no exception is raised and the target keeps its value.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            blocked_r <= 1'b0;
        end else begin
            blocked_r <= prot_req.valid && prot_locked; // [RULE12]
        end
    end

    // Outputs.
    assign sr_rdata = rdata_r;
    assign sr_rd_valid = rd_valid_r;
    assign irq_accept = accept_r;
    assign irq_hold = hold_r;
    assign system_error_exception = system_error_exception_r;
    assign prot_wr_allow = prot_req.valid && !prot_locked; // [RULE8]
    assign prot_wr_blocked = blocked_r;
    assign table_base_addr = img_table_base; // [RULE1]
    assign bank_number_upper_limit = limit_r;
    assign priority_mask_level = mask_r;
    assign supervisor_lock_flag = lock_r;

endmodule : gilr_regs
`default_nettype wire

// >>> inc/gilr_pkg.sv
// Package with constants and carrier types for the guest interrupt registers.
package gilr_pkg;

    // Register selectors on the system register port.
    localparam logic [2:0] GILR_SEL_TABLE_BASE = 3'h0;
    localparam logic [2:0] GILR_SEL_INT_CONFIG = 3'h1;
    localparam logic [2:0] GILR_SEL_PRIO_MASK = 3'h2;
    localparam logic [2:0] GILR_SEL_SV_LOCK = 3'h3;

    // Table base field position and reset value.
    localparam int GILR_TBASE_LSB = 9;
    localparam int GILR_TBASE_MSB = 31;
    localparam logic [22:0] GILR_TBASE_RST = 23'h000000;

    // Interrupt configuration fields.
    localparam int GILR_LIMIT_LSB = 16;
    localparam int GILR_LIMIT_MSB = 21;
    localparam logic [5:0] GILR_LIMIT_RST = 6'h0f;
    localparam int GILR_EXT_BIT = 1;
    localparam logic GILR_EXT_VALUE = 1'b1;
    localparam int GILR_ISP_BIT = 0;
    localparam logic GILR_ISP_VALUE = 1'b0;

    // Priority mask field.
    localparam int GILR_MASK_LSB = 0;
    localparam int GILR_MASK_MSB = 5;
    localparam logic [5:0] GILR_MASK_RST = 6'h3f;

    // Supervisor lock field.
    localparam int GILR_LOCK_BIT = 0;
    localparam logic GILR_LOCK_RST = 1'b0;

    // Bank index that is never usable.
    localparam logic [5:0] GILR_BANK_INVALID = 6'h3f;

    // System register access request.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [2:0] sel;
    } gilr_sr_req_t;

    // External maskable interrupt request offered for acceptance.
    typedef struct packed {
        logic valid;
        logic uses_bank;
        logic [5:0] priority_level;
    } gilr_irq_t;

    // Protection registers a write can target; the lock guards all but the two direct ones.
    typedef enum logic [2:0] {
        GILR_PT_GPID_DIRECT,
        GILR_PT_GPID_ACTIVE,
        GILR_PT_GMPM_DIRECT,
        GILR_PT_GMPM_ACTIVE,
        GILR_PT_MPU_LOWER,
        GILR_PT_MPU_UPPER,
        GILR_PT_MPU_ATTR,
        GILR_PT_MPU_IDBANK
    } gilr_prot_target_t;

    // Write attempt to a protection related register.
    typedef struct packed {
        logic valid;
        logic sv_mode;
        gilr_prot_target_t target;
    } gilr_prot_req_t;

endpackage : gilr_pkg

// >>> verif/gilr_regs_asserts.sv
// Port-level assertions for the guest interrupt register block.
`timescale 1ns/100ps
`default_nettype none
module gilr_regs_asserts (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire gilr_pkg::gilr_sr_req_t sr_req,
    input wire logic [31:0] sr_wdata,
    input wire logic [31:0] sr_rdata,
    input wire logic sr_rd_valid,
    input wire gilr_pkg::gilr_irq_t irq_req,
    input wire logic interrupt_disable_flag,
    input wire logic [5:0] current_bank_index,
    input wire logic irq_accept,
    input wire logic irq_hold,
    input wire logic system_error_exception,
    input wire gilr_pkg::gilr_prot_req_t prot_req,
    input wire logic prot_wr_allow,
    input wire logic prot_wr_blocked,
    input wire logic [31:0] table_base_addr,
    input wire logic [5:0] bank_number_upper_limit,
    input wire logic [5:0] priority_mask_level,
    input wire logic supervisor_lock_flag
);
    // Admission and bank fault are rebuilt here from the inputs alone.
    logic adm;
    logic flt;
    logic dir;
    assign adm = irq_req.valid && !interrupt_disable_flag &&
        (irq_req.priority_level < priority_mask_level);
    assign flt = irq_req.uses_bank && (current_bank_index >
        bank_number_upper_limit || current_bank_index == 6'h3f);
    assign dir = prot_req.target == gilr_pkg::GILR_PT_GPID_DIRECT ||
        prot_req.target == gilr_pkg::GILR_PT_GMPM_DIRECT;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // A configuration read request; its answer is checked one cycle on.
    sequence cfg_read;
        sr_req.rd && sr_req.sel == gilr_pkg::GILR_SEL_INT_CONFIG;
    endsequence
    // A supervisor write attempt while the lock is set.
    sequence locked_try;
        prot_req.valid && prot_req.sv_mode && supervisor_lock_flag && !dir;
    endsequence
    chk_base_low: assert property (table_base_addr[8:0] == 9'h000)
        else $error("table base low bits not zero");
    chk_limit_write: assert property (
        sr_req.wr && sr_req.sel == gilr_pkg::GILR_SEL_INT_CONFIG |=>
        bank_number_upper_limit == $past(sr_wdata[21:16]))
        else $error("bank limit not written");
    chk_bank_hold: assert property (
        adm && flt |=> irq_hold && system_error_exception && !irq_accept)
        else $error("bank fault not held");
    chk_cfg_consts: assert property (
        cfg_read |=> sr_rd_valid && sr_rdata[15:0] == 16'h0002)
        else $error("configuration constant bits wrong");
    chk_irq_accept: assert property (
        adm && !flt |=> irq_accept && !irq_hold)
        else $error("admitted interrupt not accepted");
    chk_irq_block: assert property (
        !adm |=> !irq_accept && !irq_hold && !system_error_exception)
        else $error("masked interrupt answered");
    chk_lock_block: assert property (
        locked_try |-> !prot_wr_allow ##1 prot_wr_blocked)
        else $error("locked write not blocked");
    chk_direct_pass: assert property (prot_req.valid &&
        prot_req.target == gilr_pkg::GILR_PT_GPID_DIRECT |-> prot_wr_allow)
        else $error("direct protection id write refused");
    chk_lock_keep: assert property (
        !(sr_req.wr && sr_req.sel == gilr_pkg::GILR_SEL_SV_LOCK) |=>
        $stable(supervisor_lock_flag))
        else $error("lock flag changed without write");
endmodule : gilr_regs_asserts
bind gilr_regs gilr_regs_asserts u_chk (.*);
`default_nettype wire

// >>> verif/tb_top.sv
// Self-checking bench for the guest interrupt register block.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    gilr_pkg::gilr_sr_req_t sr_req = '0;
    logic [31:0] sr_wdata = 32'h0;
    gilr_pkg::gilr_irq_t irq_req = '0;
    logic interrupt_disable_flag = 1'b0;
    logic [5:0] current_bank_index = 6'h00;
    gilr_pkg::gilr_prot_req_t prot_req = '0;
    logic [31:0] sr_rdata, table_base_addr;
    logic sr_rd_valid, irq_accept, irq_hold, system_error_exception;
    logic prot_wr_allow, prot_wr_blocked, supervisor_lock_flag;
    logic [5:0] bank_number_upper_limit, priority_mask_level;
    logic [31:0] seed = 32'h1f7e25f6;
    logic [31:0] d;
    logic [5:0] m, l;
    logic blk;
    int mismatches = 0;
    int samples_checked = 0;
    int i;
    gilr_regs dut (.*);
    // Free-running 100 MHz clock.
    always #5 clk_sys = ~clk_sys;
    // Xorshift keeps the random stream repeatable.
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // Expected read image of a written word; unmapped selectors read zero.
    function automatic logic [31:0] img(logic [2:0] s, logic [31:0] v);
        case (s)
            3'h0: return {v[31:9], 9'h000};
            3'h1: return {10'h000, v[21:16], 14'h0000, 2'b10};
            3'h2: return {26'h0, v[5:0]};
            3'h3: return {31'h0, v[0]};
            default: return 32'h0;
        endcase
    endfunction : img
    // Clear reserved fields before a write; software keeps them zero.
    function automatic logic [31:0] legal(logic [2:0] s, logic [31:0] v);
        case (s)
            3'h0: return {v[31:9], 9'h000};
            3'h1: return {10'h000, v[21:16], 14'h0000, v[1:0]};
            3'h2: return {26'h0, v[5:0]};
            3'h3: return {31'h0, v[0]};
            default: return v;
        endcase
    endfunction : legal
    // One comparison, counted, reported at once on mismatch.
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Register write: request held for one sampling edge.
    task automatic wr(logic [2:0] s, logic [31:0] v);
        @(negedge clk_sys);
        sr_req = {1'b1, 1'b0, s};
        sr_wdata = v;
        @(negedge clk_sys);
        sr_req = '0;
    endtask : wr
    // Register read: the answer stands right after the taking edge and is checked at the next falling edge.
    task automatic rd(logic [2:0] s, logic [31:0] exp);
        @(negedge clk_sys);
        sr_req = {1'b0, 1'b1, s};
        @(negedge clk_sys);
        sr_req = '0;
        chk({31'h0, sr_rd_valid}, 32'h1);
        chk(sr_rdata, exp);
    endtask : rd
    // Offer one interrupt and compare the answer against the bench model.
    task automatic irq(logic [7:0] r, logic f, logic [5:0] b);
        logic a, h;
        a = r[7] && !f && r[5:0] < m;
        h = a && r[6] && (b > l || b == 6'h3f);
        @(negedge clk_sys);
        irq_req = r;
        interrupt_disable_flag = f;
        current_bank_index = b;
        @(negedge clk_sys);
        irq_req = '0;
        chk({irq_accept, irq_hold, system_error_exception}, {a && !h, h, h});
    endtask : irq
    // Print the counts and the verdict, then stop.
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish
    // Main sequence: reset values, register traffic, interrupts, lock.
    initial begin
        repeat (10) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_b = 1'b1;
        for (i = 0; i < 8; i++) begin
            d = i == 2 ? 32'h3f : i == 0 ? 32'h0 : 32'h000f0000;
            rd(i[2:0], img(i[2:0], d));
        end
        $display("test reset values done");
        for (i = 0; i < 64; i++) begin
            d = (i < 8) ? 32'hffffffff : rnd();
            wr(i[2:0], legal(i[2:0], d));
            rd(i[2:0], img(i[2:0], d));
            if (i[2:0] == 3'h0) begin
                chk(table_base_addr, img(3'h0, d));
            end else if (i[2:0] == 3'h1) begin
                chk(bank_number_upper_limit, d[21:16]);
            end else if (i[2:0] == 3'h2) begin
                chk(priority_mask_level, d[5:0]);
            end else if (i[2:0] == 3'h3) begin
                chk(supervisor_lock_flag, d[0]);
            end
        end
        $display("test register access done");
        for (i = 0; i < 400; i++) begin
            d = rnd();
            if (i % 4 == 0) begin
                m = (i < 16) ? {4'h0, i[3:2]} : d[21:16];
                l = d[29:24];
                wr(3'h2, {26'h0, m});
                wr(3'h1, {10'h0, l, 16'h0});
            end
            irq({d[7] | d[11], d[6], d[12] ? d[5:0] : {5'h0, d[0]}}, d[8] & d[9],
                i % 8 == 0 ? 6'h3f : i % 8 == 1 ? l : d[15:10]);
        end
        $display("test interrupt gating done");
        for (i = 0; i < 32; i++) begin
            if (i[3:0] == 4'h0) begin
                wr(3'h3, {31'h0, i[4]});
            end
            blk = i[4] && i[3] && i[2:0] != 3'h0 && i[2:0] != 3'h2;
            @(negedge clk_sys);
            prot_req = {1'b1, i[3], i[2:0]};
            #1 chk({31'h0, prot_wr_allow}, {31'h0, !blk});
            @(negedge clk_sys);
            prot_req = '0;
            chk({31'h0, prot_wr_blocked}, {31'h0, blk});
        end
        rd(3'h3, 32'h1);
        $display("test supervisor lock done");
        tally_and_finish();
    end
    // Watchdog: the tests need well under this span.
    initial begin
        #500000;
        mismatches++;
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
